// file: rtl/serial_port_params.svh
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// Register byte addresses on the APB.
`define FMT_OFFSET        8'h00
`define BAUD_OFFSET       8'h04
`define CTRL_OFFSET       8'h08
`define TXB_OFFSET        8'h0C
`define FLAGS_OFFSET      8'h10
`define RXB_OFFSET        8'h14

// Reset values.
`define FMT_RESET         8'h00
`define BAUD_RESET        8'hFF
`define CTRL_RESET        8'h00
`define TXB_RESET         8'hFF
`define RXB_RESET         8'h00

// Frame format control fields.
`define FMT_SYNC_BIT      7
`define FMT_CHR7_BIT      6
`define FMT_PAR_EN_BIT    5
`define FMT_PAR_ODD_BIT   4
`define FMT_STOP2_BIT     3
`define FMT_MP_BIT        2
`define FMT_CKS_MSB       1
`define FMT_CKS_LSB       0

// Control fields.
`define CTRL_TX_EN_BIT    5
`define CTRL_RX_EN_BIT    4

// Flag fields.
`define FLG_TX_EMPTY_BIT  7
`define FLG_RX_FULL_BIT   6
`define FLG_OVERRUN_BIT   5
`define FLG_FRAMING_BIT   4
`define FLG_PARITY_BIT    3
`define FLG_TX_END_BIT    2
`define FLG_MPB_RX_BIT    1
`define FLG_MPB_TX_BIT    0

// Last count of each baud prescaler: divide by 4, 16 and 64.
`define PRE_LAST_DIV4     2'h3
`define PRE_LAST_DIV16    4'hF
`define PRE_LAST_DIV64    6'h3F

// Oversampling: last tick of a bit, mid-bit tick and last data bit index for 8- and 7-bit characters.
`define LAST_TICK         4'hF
`define MID_TICK          4'h7
`define LAST_BIT8         3'h7
`define LAST_BIT7         3'h6

`endif

// file: rtl/serial_pkg.sv
package serial_pkg;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_EXTRA, TX_STOP1, TX_STOP2
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_EXTRA, RX_STOP
  } rx_state_t;

  typedef struct packed {
    logic [7:0]  fmt;
    logic [7:0]  baud;
    logic [7:0]  ctrl;
    logic [7:0]  txb;
    logic [7:0]  rxb;
    logic        tx_empty;
    logic        rx_full;
    logic        overrun;
    logic        framing;
    logic        parity_err;
    logic        tx_end;
    logic        mpb_rx;
    logic        mpb_tx;
    tx_state_t   tx_st;
    logic [7:0]  tx_shift;
    logic [2:0]  tx_bit;
    logic [3:0]  tx_tick;
    logic        tx_extra;
    logic        txd;
    rx_state_t   rx_st;
    logic [7:0]  rx_shift;
    logic [2:0]  rx_bit;
    logic [3:0]  rx_tick;
    logic        rx_extra;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } main_state_t;

  typedef struct packed {
    logic [5:0] pre_cnt;
    logic [7:0] div_cnt;
    logic       tick;
  } tick_state_t;

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_t;

endpackage

// file: rtl/tick_if.sv
`timescale 1ns/1ps
interface tick_if;
  logic [1:0] prescale_select;
  logic [7:0] divisor;
  logic       tick;

  modport gen (input prescale_select, input divisor, output tick);
  modport use_tick (output prescale_select, output divisor, input tick);
endinterface

// file: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and result.
  input  wire logic pin_in,
  output logic      pin_sync_out
);
  serial_pkg::sync_state_t s_r;
  serial_pkg::sync_state_t s_nxt;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.meta   = pin_in;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= 2'b11;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pin_sync_out = s_r.stable;
endmodule // pin_sync

// file: rtl/baud_tick_gen.sv
`timescale 1ns/1ps
`include "serial_port_params.svh"
module baud_tick_gen (
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Rate settings and oversample tick.
  tick_if.gen       tk
);
  serial_pkg::tick_state_t s_r;
  serial_pkg::tick_state_t s_nxt;
  logic                    base_tick;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.pre_cnt = s_r.pre_cnt + 6'h01;
    s_nxt.tick    = 1'b0;
    unique case (tk.prescale_select)
      2'b00: base_tick = 1'b1;
      2'b01: base_tick = (s_r.pre_cnt[1:0] == `PRE_LAST_DIV4);
      2'b10: base_tick = (s_r.pre_cnt[3:0] == `PRE_LAST_DIV16);
      2'b11: base_tick = (s_r.pre_cnt == `PRE_LAST_DIV64);
    endcase
    // The divisor gives one oversample tick every divisor+1 prescaled clocks.
    if (base_tick) begin
      if (s_r.div_cnt >= tk.divisor) begin
        s_nxt.div_cnt = 8'h00;
        s_nxt.tick    = 1'b1;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tk.tick = s_r.tick;
endmodule // baud_tick_gen

// file: rtl/serial_port.sv
// Notes on behaviour
// - Receiver shifts bits in least significant first, then moves byte to buffer.
// - Both shifters are internal; software cannot read or write them.
// - Receive shifter takes the next character at once after each transfer.
// - Receive byte buffer is read-only, cleared by reset and standby.
// - Transmitter sends the transmit shifter least significant bit first.
// - Empty transmit shifter is loaded from the buffer and serialising begins.
// - After a byte, next byte loads unless the transmit empty flag is set.
// - Transmit byte buffer is read/write, set to all ones by reset and standby.
// - Frame format control is read/write, cleared by reset and standby.
// - Format bit 7 picks asynchronous (0) or synchronous (1) operation.
// - Format bit 6 picks 8 or 7 data bits; synchronous always 8.
// - With 7-bit characters bit 7 of the transmit buffer is not sent.
// - Format bit 5 enables parity in asynchronous mode only.
// - Format bit 4 picks even (0) or odd (1) parity sense.
// - With parity on, receiver checks ones count against the selected sense.
// - Format bit 3 gives one or two high stop bits in asynchronous mode.
// - Receiver checks only the first stop bit.
// - A low where a second stop bit would be starts the next character.
// - Format bit 2 selects multiprocessor format, overriding parity settings.
// - Format bits 1:0 divide the baud clock by 1, 4, 16 or 64.
// - With transmit enabled, sending starts once software clears the empty flag.
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "serial_port_params.svh"
module serial_port (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Low-power standby request, same clock domain.
  input  wire logic        standby,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins.
  input  wire logic        rxd,
  output logic             txd
);
  localparam serial_pkg::main_state_t RESET_STATE = '{
    fmt:      `FMT_RESET,
    baud:     `BAUD_RESET,
    ctrl:     `CTRL_RESET,
    txb:      `TXB_RESET,
    rxb:      `RXB_RESET,
    tx_empty: 1'b1,
    tx_end:   1'b1,
    tx_st:    serial_pkg::TX_IDLE,
    rx_st:    serial_pkg::RX_IDLE,
    txd:      1'b1,
    default:  '0
  };

  serial_pkg::main_state_t s_r;
  serial_pkg::main_state_t s_nxt;

  tick_if tk ();

  logic       rxd_s;
  logic       tick;
  logic       sync_mode;
  logic       chr7;
  logic       extra_en;
  logic       tx_en;
  logic       rx_en;
  logic       tx_bit_end;
  logic       tx_go;
  logic       rx_bit_end;
  logic       wr_done;
  logic       rd_take;
  logic       addr_hit;
  logic [7:0] rd_byte;
  logic [7:0] flags;
  logic [7:0] tx_load;
  logic [7:0] rx_byte;
  logic [2:0] tx_last;
  logic [2:0] rx_last;

  pin_sync u_rx_sync (
    .pclk         (pclk),
    .presetn      (presetn),
    .pin_in       (rxd),
    .pin_sync_out (rxd_s)
  );

  baud_tick_gen u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tk.gen)
  );

  assign tk.prescale_select = s_r.fmt[`FMT_CKS_MSB:`FMT_CKS_LSB];
  assign tk.divisor         = s_r.baud;
  assign tick               = tk.tick;

  // Format decode; synchronous mode overrides length, parity and stops.
  assign sync_mode = s_r.fmt[`FMT_SYNC_BIT];
  assign chr7      = s_r.fmt[`FMT_CHR7_BIT] && !sync_mode;
  assign extra_en  = !sync_mode && (s_r.fmt[`FMT_PAR_EN_BIT] || s_r.fmt[`FMT_MP_BIT]);
  assign tx_en     = s_r.ctrl[`CTRL_TX_EN_BIT];
  assign rx_en     = s_r.ctrl[`CTRL_RX_EN_BIT];
  assign tx_last   = chr7 ? `LAST_BIT7 : `LAST_BIT8;
  assign rx_last   = tx_last;

  assign tx_bit_end = tick && (s_r.tx_tick == `LAST_TICK);
  assign rx_bit_end = tick && (s_r.rx_tick == `LAST_TICK);

  // The top bit is masked off for 7-bit characters before it can be sent.
  assign tx_load = chr7 ? {1'b0, s_r.txb[6:0]} : s_r.txb;

  // A 7-bit character sits in the upper seven bits of the shifter.
  assign rx_byte = chr7 ? {1'b0, s_r.rx_shift[7:1]} : s_r.rx_shift;

  assign flags = {s_r.tx_empty, s_r.rx_full, s_r.overrun, s_r.framing,
                  s_r.parity_err, s_r.tx_end, s_r.mpb_rx, s_r.mpb_tx};

  // APB answers one cycle into the access phase; writes land on completion.
  assign rd_take = psel && penable && !s_r.pready;
  assign wr_done = psel && penable && s_r.pready && pwrite;

  always_comb begin
    addr_hit = 1'b1;
    rd_byte  = 8'h00;
    unique case (paddr)
      `FMT_OFFSET:   rd_byte = s_r.fmt;
      `BAUD_OFFSET:  rd_byte = s_r.baud;
      `CTRL_OFFSET:  rd_byte = s_r.ctrl;
      `TXB_OFFSET:   rd_byte = s_r.txb;
      `FLAGS_OFFSET: rd_byte = flags;
      `RXB_OFFSET:   rd_byte = s_r.rxb;
      default:       addr_hit = 1'b0;
    endcase
  end

  always_comb begin
    s_nxt         = s_r;
    tx_go         = 1'b0;
    s_nxt.pready  = 1'b0;

    // Bus side.
    if (rd_take) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = !addr_hit;
      s_nxt.prdata  = {24'h000000, rd_byte};
    end
    if (wr_done && !s_r.pslverr) begin
      unique case (paddr)
        `FMT_OFFSET:  s_nxt.fmt  = pwdata[7:0];
        `BAUD_OFFSET: s_nxt.baud = pwdata[7:0];
        `CTRL_OFFSET: s_nxt.ctrl = pwdata[7:0];
        `TXB_OFFSET:  s_nxt.txb  = pwdata[7:0];
        `FLAGS_OFFSET: begin
          // Status flags only accept zeros and tx_end is not writable; the multiprocessor transmit bit is plain.
          s_nxt.tx_empty   = s_r.tx_empty & pwdata[`FLG_TX_EMPTY_BIT];
          s_nxt.rx_full    = s_r.rx_full & pwdata[`FLG_RX_FULL_BIT];
          s_nxt.overrun    = s_r.overrun & pwdata[`FLG_OVERRUN_BIT];
          s_nxt.framing    = s_r.framing & pwdata[`FLG_FRAMING_BIT];
          s_nxt.parity_err = s_r.parity_err & pwdata[`FLG_PARITY_BIT];
          s_nxt.mpb_tx     = pwdata[`FLG_MPB_TX_BIT];
        end
        default: ;
      endcase
    end

    // Transmitter; the shifter is never visible on the bus.
    if (s_r.tx_st != serial_pkg::TX_IDLE && tick) begin
      s_nxt.tx_tick = s_r.tx_tick + 4'h1;
    end
    unique case (s_r.tx_st)
      serial_pkg::TX_IDLE: begin
        tx_go = 1'b1;
      end
      serial_pkg::TX_START: begin
        if (tx_bit_end) begin
          s_nxt.tx_st = serial_pkg::TX_DATA;
          s_nxt.txd   = s_r.tx_shift[0];
        end
      end
      serial_pkg::TX_DATA: begin
        if (tx_bit_end) begin
          if (s_r.tx_bit == tx_last) begin
            if (extra_en) begin
              s_nxt.tx_st = serial_pkg::TX_EXTRA;
              s_nxt.txd   = s_r.tx_extra;
            end else if (!sync_mode) begin
              s_nxt.tx_st = serial_pkg::TX_STOP1;
              s_nxt.txd   = 1'b1;
            end else begin
              tx_go = 1'b1;
            end
          end else begin
            s_nxt.tx_bit   = s_r.tx_bit + 3'h1;
            s_nxt.tx_shift = {1'b0, s_r.tx_shift[7:1]};
            s_nxt.txd      = s_r.tx_shift[1];
          end
        end
      end
      serial_pkg::TX_EXTRA: begin
        if (tx_bit_end) begin
          s_nxt.tx_st = serial_pkg::TX_STOP1;
          s_nxt.txd   = 1'b1;
        end
      end
      serial_pkg::TX_STOP1: begin
        if (tx_bit_end) begin
          if (s_r.fmt[`FMT_STOP2_BIT]) begin
            s_nxt.tx_st = serial_pkg::TX_STOP2;
          end else begin
            tx_go = 1'b1;
          end
        end
      end
      serial_pkg::TX_STOP2: begin
        if (tx_bit_end) begin
          tx_go = 1'b1;
        end
      end
      default: begin
        s_nxt.tx_st = serial_pkg::TX_IDLE;
      end
    endcase

    // The shifter is empty here: reload from the buffer or go idle.
    if (tx_go) begin
      if (tx_en && !s_r.tx_empty) begin
        s_nxt.tx_shift = tx_load;
        s_nxt.tx_extra = s_r.fmt[`FMT_MP_BIT] ? s_r.mpb_tx
                         : ((^tx_load) ^ s_r.fmt[`FMT_PAR_ODD_BIT]);
        s_nxt.tx_empty = 1'b1;
        s_nxt.tx_end   = 1'b0;
        s_nxt.tx_bit   = 3'h0;
        s_nxt.tx_tick  = 4'h0;
        s_nxt.tx_st    = sync_mode ? serial_pkg::TX_DATA : serial_pkg::TX_START;
        s_nxt.txd      = sync_mode ? tx_load[0] : 1'b0;
      end else begin
        s_nxt.tx_st  = serial_pkg::TX_IDLE;
        s_nxt.txd    = 1'b1;
        s_nxt.tx_end = 1'b1;
      end
    end
    if (!tx_en) begin
      s_nxt.tx_empty = 1'b1;
    end

    // Receiver, asynchronous frames only; the shifter is internal.
    if (s_r.rx_st != serial_pkg::RX_IDLE && tick) begin
      s_nxt.rx_tick = s_r.rx_tick + 4'h1;
    end
    unique case (s_r.rx_st)
      serial_pkg::RX_IDLE: begin
        // A low line while idle is a start bit, including in a second stop slot.
        if (rx_en && !sync_mode && !rxd_s) begin
          s_nxt.rx_st   = serial_pkg::RX_START;
          s_nxt.rx_tick = 4'h0;
          s_nxt.rx_bit  = 3'h0;
        end
      end
      serial_pkg::RX_START: begin
        // Re-check at mid bit so a glitch does not start a frame.
        if (tick && s_r.rx_tick == `MID_TICK) begin
          s_nxt.rx_tick = 4'h0;
          s_nxt.rx_st   = rxd_s ? serial_pkg::RX_IDLE : serial_pkg::RX_DATA;
        end
      end
      serial_pkg::RX_DATA: begin
        if (rx_bit_end) begin
          s_nxt.rx_shift = {rxd_s, s_r.rx_shift[7:1]};
          s_nxt.rx_bit   = s_r.rx_bit + 3'h1;
          if (s_r.rx_bit == rx_last) begin
            s_nxt.rx_st = extra_en ? serial_pkg::RX_EXTRA : serial_pkg::RX_STOP;
          end
        end
      end
      serial_pkg::RX_EXTRA: begin
        if (rx_bit_end) begin
          s_nxt.rx_extra = rxd_s;
          s_nxt.rx_st    = serial_pkg::RX_STOP;
        end
      end
      serial_pkg::RX_STOP: begin
        // Only the first stop bit is sampled; the shifter is free at once.
        if (rx_bit_end) begin
          s_nxt.rx_st = serial_pkg::RX_IDLE;
          if (!rxd_s) begin
            s_nxt.framing = 1'b1;
          end
          if (s_r.fmt[`FMT_MP_BIT]) begin
            s_nxt.mpb_rx = s_r.rx_extra;
          end else if (s_r.fmt[`FMT_PAR_EN_BIT] &&
                       ((^rx_byte) ^ s_r.rx_extra) != s_r.fmt[`FMT_PAR_ODD_BIT]) begin
            s_nxt.parity_err = 1'b1;
          end
          if (s_r.rx_full) begin
            s_nxt.overrun = 1'b1;
          end else begin
            s_nxt.rxb     = rx_byte;
            s_nxt.rx_full = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.rx_st = serial_pkg::RX_IDLE;
      end
    endcase
    if (!rx_en && s_r.rx_st != serial_pkg::RX_IDLE) begin
      s_nxt.rx_st = serial_pkg::RX_IDLE;
    end

    // Standby returns every register of this module and both shifters to their reset values, except pready, which still answers an access in the next cycle.
    if (standby) begin
      s_nxt        = RESET_STATE;
      s_nxt.pready = rd_take;
      s_nxt.prdata = 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign txd     = s_r.txd;
endmodule // serial_port

// file: tb/serial_port_asserts.sv
`timescale 1ns/1ps
module serial_port_asserts (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        standby,
  // APB slave.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Serial output.
  input wire logic        txd
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic mapped;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};

  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_ready_slot: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered in the next cycle");
  a_ready_cause: assert property (pready |-> psel && penable)
    else $error("ready without an access");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_bad_addr: assert property (pready && !mapped |-> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  a_good_addr: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_standby_idle: assert property (standby |=> txd)
    else $error("line not idle after standby");
  a_start_len: assert property ($fell(txd) |-> (!txd || standby) [*8])
    else $error("start bit too short");

  c_error: cover property (pready && pslverr);
  c_start: cover property ($fell(txd));
  c_read: cover property (pready && !pwrite && paddr == 8'h14);
endmodule // serial_port_asserts

bind serial_port serial_port_asserts chk_i (.pclk(pclk), .presetn(presetn), .standby(standby), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .txd(txd));

// file: tb/serial_partner.sv
`timescale 1ns/1ps
module serial_partner (
  // Clock and lines.
  input wire logic  pclk,
  input wire logic  txd,
  output logic      rxd,
  // Frame shape and result.
  input int         bit_cyc,
  input int         n_bits,
  output logic      got,
  output logic [9:0] got_val
);
  // Sends a start bit, then nb bits of w from bit 0 upward; the line is left high.
  task automatic send(input logic [9:0] w, input int nb);
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge pclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= w[i];
      repeat (bit_cyc) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask

  // Samples each bit at its middle, the stop bit landing at position n_bits.
  initial begin
    rxd = 1'b1;
    got = 1'b0;
    got_val = '0;
    forever begin
      @(negedge txd);
      got_val = '0;
      repeat (bit_cyc / 2) @(negedge pclk);
      for (int i = 0; i <= n_bits; i++) begin
        repeat (bit_cyc) @(negedge pclk);
        got_val[i] = txd;
      end
      @(posedge pclk);
      got <= 1'b1;
      @(posedge pclk);
      got <= 1'b0;
    end
  end
endmodule // serial_partner

// file: tb/test_serial_port.sv
`timescale 1ns/1ps
module test_serial_port;
  logic        pclk, presetn, standby, psel, penable, pwrite, pready, pslverr, rxd, txd, got;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  got_val;
  logic [7:0]  r;
  int          bit_cyc, n_bits, fails, n_tests;
  logic [32:0] exp_q[$], msk_q[$], tx_q[$];

  serial_port dut (.pclk(pclk), .presetn(presetn), .standby(standby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd));
  serial_partner mate (.pclk(pclk), .txd(txd), .rxd(rxd), .bit_cyc(bit_cyc), .n_bits(n_bits), .got(got),
    .got_val(got_val));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [32:0] e,
    input logic [32:0] m);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    if (pready !== 1'b1) begin
      chk(33'h0, 33'h1);
      results();
    end
    r = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00, {25'h0, e}, 33'h1FFFFFFFF);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask

  // Reads the flags until bit b is set.
  task automatic poll(input int b);
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h10, 8'h00, 33'h0, 33'h0);
      k++;
    end while (r[b] !== 1'b1 && k < 5000);
    if (r[b] !== 1'b1) begin
      chk(33'h0, 33'h1);
      results();
    end
  endtask

  function automatic logic [7:0] m7(input logic [7:0] f);
    m7 = f[6] ? 8'h7F : 8'hFF;
  endfunction

  function automatic logic par(input logic [7:0] d, input logic [7:0] f);
    par = f[4] ^ (^(d & m7(f)));
  endfunction

  function automatic int nb(input logic [7:0] f);
    nb = (f[6] ? 7 : 8) + ((f[5] || f[2]) ? 1 : 0);
  endfunction

  // Data, then the parity or multiprocessor bit, then one stop bit.
  function automatic logic [9:0] frm(input logic [7:0] d, input logic [7:0] f, input logic x);
    frm = {2'b00, d & m7(f)};
    if (f[5] || f[2])
      frm[nb(f) - 1] = x;
    frm[nb(f)] = 1'b1;
  endfunction

  always @(posedge pclk) begin
    if (pready === 1'b1 && exp_q.size() > 0)
      chk({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
    if (got === 1'b1)
      chk(33'(got_val), tx_q.size() > 0 ? tx_q.pop_front() : 33'h1FFFFFFFF);
  end

  initial begin
    logic [7:0] d, d2, f;
    logic [7:0] fl[10];
    logic mb;
    {presetn, standby, psel, penable, pwrite} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    bit_cyc = 16;
    n_bits = 8;
    fails = 0;
    n_tests = 0;
    void'($urandom(19));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h00, 8'h00);
    rd(8'h0C, 8'hFF);
    rd(8'h14, 8'h00);
    apb(1'b0, 8'h18, 8'h00, 33'h100000000, 33'h1FFFFFFFF);
    d = 8'($urandom);
    wr(8'h14, d);
    rd(8'h14, 8'h00);
    wr(8'h00, d);
    rd(8'h00, d);
    wr(8'h0C, ~d);
    rd(8'h0C, ~d);
    standby <= 1'b1;
    @(posedge pclk);
    standby <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h0C, 8'hFF);
    $display("Test registers done");
    fl = '{8'h00, 8'h08, 8'h60, 8'h70, 8'h20, 8'h44, 8'h34, 8'h01, 8'h02, 8'h03};
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h30);
    foreach (fl[i]) begin
      f = fl[i];
      bit_cyc = 16 << (2 * f[1:0]);
      n_bits = nb(f);
      mb = 1'($urandom);
      wr(8'h00, f);
      for (int j = 0; j < 2; j++) begin
        d = 8'($urandom);
        tx_q.push_back(33'(frm(d, f, f[2] ? mb : par(d, f))));
        wr(8'h0C, d);
        wr(8'h10, 8'h78 | {7'h00, mb});
        poll(7);
      end
      poll(2);
    end
    // Synchronous mode must ignore length, parity, stop and multiprocessor settings.
    // Bit 0 is kept low so the partner starts on it and sees bits 1 to 7, then the idle line.
    wr(8'h00, 8'hFC);
    bit_cyc = 16;
    n_bits = 7;
    d = {7'($urandom), 1'b0};
    tx_q.push_back({25'h0000000, 1'b1, d[7:1]});
    wr(8'h0C, d);
    wr(8'h10, 8'h78);
    poll(7);
    poll(2);
    $display("Test transmit done");
    bit_cyc = 16;
    for (int i = 0; i < 2; i++) begin
      f = i ? 8'h68 : 8'h08;
      wr(8'h00, f);
      d = 8'($urandom);
      d2 = 8'($urandom);
      fork
        begin
          mate.send(frm(d, f, par(d, f)), nb(f) + 1);
          mate.send(frm(d2, f, par(d2, f)), nb(f) + 1);
        end
      join_none
      poll(6);
      rd(8'h14, d & m7(f));
      wr(8'h10, 8'hBF);
      poll(6);
      rd(8'h14, d2 & m7(f));
      apb(1'b0, 8'h10, 8'h00, 33'h0, 33'h38);
      wr(8'h10, 8'hBF);
    end
    mate.send(frm(d, f, ~par(d, f)) & ~(10'h001 << nb(f)), nb(f) + 1);
    poll(4);
    apb(1'b0, 8'h10, 8'h00, 33'h18, 33'h18);
    $display("Test receive done");
    repeat (20) @(posedge pclk);
    results();
  end
endmodule // test_serial_port
